/* File: core/load_detect_defines.svh */
// named offsets, field positions, reset values and timing figures for the load-detect block
// assumes inclusion by bare name from any design file that needs them
`ifndef LOAD_DETECT_DEFINES_SVH
`define LOAD_DETECT_DEFINES_SVH

// clock and timer figures, times in their own units
`define LD_CLK_NS 4
`define LD_TICK_NS 1000000
`define LD_PW_DISCH_MS 330
`define LD_QUAL_MS 200
`define LD_REL_S 3
`define LD_PW_REL_S 15
`define LD_MS_PER_S 1000

// register byte offsets
`define LD_REG_CTRL 4'h0
`define LD_REG_STATE 4'h4
`define LD_REG_IRQ_STATUS 4'h8
`define LD_REG_IRQ_MASK 4'hc

// control register fields and reset value
`define LD_CTRL_ENABLE 0
`define LD_CTRL_RESET 32'h0000_0001

// state register fields
`define LD_ST_LOAD 0
`define LD_ST_HOT 1
`define LD_ST_PW_LO 4
`define LD_ST_PW_HI 6
`define LD_ST_MODE_LO 8
`define LD_ST_MODE_HI 14

// interrupt bits
`define LD_IRQ_W 4
`define LD_IRQ_ASSERT 0
`define LD_IRQ_RELEASE 1
`define LD_IRQ_WAKE 2
`define LD_IRQ_THERMAL 3

// axi responses
`define LD_RESP_OKAY 2'h0
`define LD_RESP_SLVERR 2'h2

`endif

/* File: core/load_detect_pkg.sv */
// types shared by the load-detect block: modes, limits, power-wake states, carriers
// assumes load_detect_defines.svh supplies the numeric constants
package load_detect_pkg;

  // charging mode decoded from the mode pins, one-hot
  typedef enum logic [6:0] {
    M_DISCHARGE = 7'h01,
    M_DCP_AUTO = 7'h02,
    M_SDP1 = 7'h04,
    M_STANDARD_DOWNSTREAM_MODE_TWO = 7'h08,
    M_CDP = 7'h10,
    M_DCP_SHORT = 7'h20,
    M_DIVIDER = 7'h40
  } mode_t;

  // which current limit the analog switch applies
  typedef enum logic [1:0] {
    LIM_NONE = 2'h0,
    LIM_PW = 2'h1,
    LIM_LO = 2'h2,
    LIM_HI = 2'h3
  } limit_t;

  // kind of load detection active in the current mode
  typedef enum logic [1:0] {
    LD_NONE = 2'h0,
    LD_PW = 2'h1,
    LD_LIMITS = 2'h2,
    LD_CDP = 2'h3
  } detect_t;

  // power-wake sequence, one-hot
  typedef enum logic [2:0] {
    PW_IDLE = 3'h1,
    PW_DISCH = 3'h2,
    PW_ON = 3'h4
  } pw_state_t;

  // comparator and sensor levels, already synchronous
  typedef struct packed {
    logic above_pw_limit;
    logic below_pw_low;
    logic above_upper;
    logic below_lower;
    logic bc12_detect;
    logic thermal_hot;
  } sense_t;

  // drive to the analog power path
  typedef struct packed {
    logic switch_on;
    logic discharge;
    limit_t limit;
    logic data_connect;
  } port_drive_t;

endpackage

/* File: core/interval_timer.sv */
// tick-counting interval timer: counts timer ticks while run is high
// assumes tick is a one-cycle enable from a free-running divider
`timescale 1ns/1ps
module interval_timer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic tick,
  input wire logic run,
  input wire logic [WIDTH-1:0] limit,
  // result
  output logic done
);

  logic [WIDTH-1:0] count_q;

  // count saturates at the limit; dropping run restarts the interval from zero
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count_q <= '0;
    end else if (tick && count_q != limit) begin
      count_q <= count_q + 1'b1;
    end
  end

  // done held as a flop so a qualified condition cannot glitch the outputs
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      done <= 1'b0;
    end else begin
      done <= (count_q == limit);
    end
  end

endmodule

/* File: core/usb_port_load_detect_ctrl.sv */
// load detection and port power sequencing for a usb charging-port switch
// assumes comparator and sensor inputs are synchronous to aclk; axi4-lite register access
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "load_detect_defines.svh"

module usb_port_load_detect_ctrl #(
  parameter int TICK_CYCLES = `LD_TICK_NS / `LD_CLK_NS,
  parameter int PW_DISCH_TICKS = `LD_PW_DISCH_MS,
  parameter int QUAL_TICKS = `LD_QUAL_MS,
  parameter int REL_TICKS = `LD_REL_S * `LD_MS_PER_S,
  parameter int PW_REL_TICKS = `LD_PW_REL_S * `LD_MS_PER_S,
  parameter int TW = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // mode pins from the power-management controller
  input wire logic mode_pin_one,
  input wire logic mode_pin_two,
  input wire logic mode_pin_three,
  input wire logic limit_select_pin,
  // comparator and thermal levels
  input wire load_detect_pkg::sense_t sense,
  // port outputs
  output logic load_present_n,
  output load_detect_pkg::port_drive_t drive,
  output logic irq,
  // axi4-lite slave
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  localparam int NT = 4;

  load_detect_pkg::mode_t mode;
  load_detect_pkg::limit_t mode_limit;
  load_detect_pkg::detect_t detect;
  load_detect_pkg::pw_state_t pw_q;
  logic [31:0] ctrl_q;
  logic [`LD_IRQ_W-1:0] irq_status_q;
  logic [`LD_IRQ_W-1:0] irq_mask_q;
  logic [`LD_IRQ_W-1:0] events;
  logic lp_q;
  logic hot_q;
  logic enable;
  logic [31:0] div_q;
  logic tick;
  logic [NT-1:0] t_run;
  logic [NT-1:0] t_done;
  logic [TW-1:0] t_limit [NT];
  logic aw_have_q;
  logic w_have_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] rd_word;
  logic rd_ok;

  assign enable = ctrl_q[`LD_CTRL_ENABLE];

  // mode decode from the four pins
  always_comb begin
    mode = load_detect_pkg::M_SDP1;
    mode_limit = limit_select_pin ? load_detect_pkg::LIM_HI : load_detect_pkg::LIM_LO;
    detect = load_detect_pkg::LD_NONE;
    unique case ({mode_pin_one, mode_pin_two, mode_pin_three})
      3'h0: begin
        mode = load_detect_pkg::M_DISCHARGE;
        mode_limit = load_detect_pkg::LIM_NONE;
      end
      3'h1: begin
        mode = load_detect_pkg::M_DCP_AUTO;
        mode_limit = load_detect_pkg::LIM_HI;
        if (limit_select_pin) begin
          detect = load_detect_pkg::LD_PW;
        end
      end
      3'h2: begin
        mode = load_detect_pkg::M_SDP1;
      end
      3'h3: begin
        mode = load_detect_pkg::M_DCP_AUTO;
        mode_limit = load_detect_pkg::LIM_HI;
        if (limit_select_pin) begin
          detect = load_detect_pkg::LD_LIMITS;
        end
      end
      3'h4: begin
        mode = load_detect_pkg::M_DCP_SHORT;
      end
      3'h5: begin
        mode = load_detect_pkg::M_DIVIDER;
      end
      3'h6: begin
        mode = load_detect_pkg::M_SDP1;
      end
      3'h7: begin
        // both codes keep the same port drive apart from limit, so no discharge between them
        mode = limit_select_pin ? load_detect_pkg::M_CDP : load_detect_pkg::M_STANDARD_DOWNSTREAM_MODE_TWO;
        detect = limit_select_pin ? load_detect_pkg::LD_CDP : load_detect_pkg::LD_NONE;
      end
    endcase
  end

  // free-running timer tick, one enable pulse per millisecond
  always_ff @(posedge aclk) begin
    if (!aresetn || div_q == TICK_CYCLES - 1) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end
  assign tick = (div_q == TICK_CYCLES - 1);

  // timers: 0 wake discharge, 1 qualify, 2 release, 3 power-wake release
  assign t_limit[0] = TW'(PW_DISCH_TICKS);
  assign t_limit[1] = TW'(QUAL_TICKS);
  assign t_limit[2] = TW'(REL_TICKS);
  assign t_limit[3] = TW'(PW_REL_TICKS);
  assign t_run[0] = (pw_q == load_detect_pkg::PW_DISCH);
  assign t_run[1] = (detect == load_detect_pkg::LD_LIMITS || detect == load_detect_pkg::LD_CDP)
                    && !lp_q && sense.above_upper;
  assign t_run[2] = (detect == load_detect_pkg::LD_LIMITS || detect == load_detect_pkg::LD_CDP)
                    && lp_q && sense.below_lower;
  assign t_run[3] = (pw_q == load_detect_pkg::PW_ON) && sense.below_pw_low;

  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_timer
      interval_timer #(
        .WIDTH(TW)
      ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .run(t_run[gi]),
        .limit(t_limit[gi]),
        .done(t_done[gi])
      );
    end
  endgenerate

  // power-wake sequence; any other mode parks it idle
  always_ff @(posedge aclk) begin
    if (!aresetn || detect != load_detect_pkg::LD_PW || !enable) begin
      pw_q <= load_detect_pkg::PW_IDLE;
    end else begin
      unique case (pw_q)
        load_detect_pkg::PW_IDLE: begin
          if (sense.above_pw_limit) begin
            pw_q <= load_detect_pkg::PW_DISCH;
          end
        end
        load_detect_pkg::PW_DISCH: begin
          if (t_done[0]) begin
            pw_q <= load_detect_pkg::PW_ON;
          end
        end
        load_detect_pkg::PW_ON: begin
          if (t_done[3]) begin
            pw_q <= load_detect_pkg::PW_IDLE;
          end
        end
        default: begin
          pw_q <= load_detect_pkg::PW_IDLE;
        end
      endcase
    end
  end

  // load-present for every detecting mode, power-wake included
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      lp_q <= 1'b0;
    end else if (detect == load_detect_pkg::LD_PW) begin
      lp_q <= (pw_q != load_detect_pkg::PW_IDLE) ||
              (pw_q == load_detect_pkg::PW_IDLE && sense.above_pw_limit);
    end else if (detect == load_detect_pkg::LD_NONE) begin
      lp_q <= 1'b0;
    end else if (detect == load_detect_pkg::LD_CDP && sense.bc12_detect) begin
      lp_q <= 1'b1;
    end else if (!lp_q && t_done[1]) begin
      lp_q <= 1'b1;
    end else if (lp_q && t_done[2]) begin
      lp_q <= 1'b0;
    end
  end
  assign load_present_n = ~lp_q;

  // thermal level registered; switch stays off while hot, retries when it clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hot_q <= 1'b0;
    end else begin
      hot_q <= sense.thermal_hot;
    end
  end

  // port drive register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive <= '{1'b0, 1'b0, load_detect_pkg::LIM_NONE, 1'b0};
    end else begin
      drive.switch_on <= enable && !sense.thermal_hot && mode != load_detect_pkg::M_DISCHARGE
                         && pw_q != load_detect_pkg::PW_DISCH;
      drive.discharge <= !enable || mode == load_detect_pkg::M_DISCHARGE
                         || pw_q == load_detect_pkg::PW_DISCH;
      drive.limit <= (pw_q == load_detect_pkg::PW_IDLE && detect == load_detect_pkg::LD_PW)
                     ? load_detect_pkg::LIM_PW : mode_limit;
      drive.data_connect <= (mode == load_detect_pkg::M_SDP1 || mode == load_detect_pkg::M_STANDARD_DOWNSTREAM_MODE_TWO
                             || mode == load_detect_pkg::M_CDP);
    end
  end

  // interrupt events: assert, release, wake discharge end, thermal shutdown
  assign events[`LD_IRQ_ASSERT] = !lp_q && (detect != load_detect_pkg::LD_NONE) && enable &&
    ((detect == load_detect_pkg::LD_PW) ? sense.above_pw_limit && pw_q == load_detect_pkg::PW_IDLE
      : ((detect == load_detect_pkg::LD_CDP && sense.bc12_detect) || t_done[1]));
  assign events[`LD_IRQ_RELEASE] = lp_q && (t_done[2] || t_done[3]);
  assign events[`LD_IRQ_WAKE] = (pw_q == load_detect_pkg::PW_DISCH) && t_done[0];
  assign events[`LD_IRQ_THERMAL] = sense.thermal_hot && !hot_q;

  // sticky status; an event in the clearing read's cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= '0;
    end else if (rd_fire && s_araddr == `LD_REG_IRQ_STATUS) begin
      irq_status_q <= events;
    end else begin
      irq_status_q <= irq_status_q | events;
    end
  end
  assign irq = |(irq_status_q & irq_mask_q);

  // axi write: address and data taken in either order, response after both
  assign s_awready = !aw_have_q && !s_bvalid;
  assign s_wready = !w_have_q && !s_bvalid;
  assign wr_fire = aw_have_q && w_have_q && !s_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn || wr_fire) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_awvalid && s_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || wr_fire) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_wvalid && s_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_wdata;
      w_strb_q <= s_wstrb;
    end
  end

  // write response; unmapped or read-only offsets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= `LD_RESP_OKAY;
    end else if (wr_fire) begin
      s_bvalid <= 1'b1;
      s_bresp <= (aw_addr_q == `LD_REG_CTRL || aw_addr_q == `LD_REG_IRQ_MASK)
                 ? `LD_RESP_OKAY : `LD_RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // writable registers, byte lane zero carries every defined bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `LD_CTRL_RESET;
      irq_mask_q <= '0;
    end else if (wr_fire && w_strb_q[0]) begin
      if (aw_addr_q == `LD_REG_CTRL) begin
        ctrl_q <= {31'h0, w_data_q[`LD_CTRL_ENABLE]};
      end
      if (aw_addr_q == `LD_REG_IRQ_MASK) begin
        irq_mask_q <= w_data_q[`LD_IRQ_W-1:0];
      end
    end
  end

  // read decode
  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    unique case (s_araddr)
      `LD_REG_CTRL: rd_word = ctrl_q;
      `LD_REG_STATE: begin
        rd_word[`LD_ST_LOAD] = lp_q;
        rd_word[`LD_ST_HOT] = hot_q;
        rd_word[`LD_ST_PW_HI:`LD_ST_PW_LO] = pw_q;
        rd_word[`LD_ST_MODE_HI:`LD_ST_MODE_LO] = mode;
      end
      `LD_REG_IRQ_STATUS: rd_word = {28'h0, irq_status_q};
      `LD_REG_IRQ_MASK: rd_word = {28'h0, irq_mask_q};
      default: rd_ok = 1'b0;
    endcase
  end

  // axi read: one outstanding, data registered
  assign s_arready = !s_rvalid;
  assign rd_fire = s_arvalid && s_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= `LD_RESP_OKAY;
    end else if (rd_fire) begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_word;
      s_rresp <= rd_ok ? `LD_RESP_OKAY : `LD_RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule

/* File: sim/load_detect_chk.sv */
// assertions on the pin-side behaviour of the load-detect block
// assumes a bind onto usb_port_load_detect_ctrl that hands on its timing parameters
`timescale 1ns/1ps
module load_detect_chk #(
  parameter int TICK_CYCLES = 4,
  parameter int PW_DISCH_TICKS = 5,
  parameter int QUAL_TICKS = 4,
  parameter int REL_TICKS = 6
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // mode pins and sense levels
  input wire logic mode_pin_one,
  input wire logic mode_pin_two,
  input wire logic mode_pin_three,
  input wire logic limit_select_pin,
  input wire load_detect_pkg::sense_t sense,
  // port outputs
  input wire logic load_present_n,
  input wire load_detect_pkg::port_drive_t drive
);
  logic [3:0] pins;
  logic [3:0] pins_q;
  logic [3:0] pins_qq;
  logic steady;
  logic lim_mode;
  int disch_q;
  int above_q;
  int below_q;
  assign pins = {mode_pin_one, mode_pin_two, mode_pin_three, limit_select_pin};
  // pins unchanged over two edges, so mode-change side effects have settled
  assign steady = (pins == pins_q) && (pins_q == pins_qq);
  assign lim_mode = (pins == 4'h7) || (pins == 4'hf);
  // run lengths of the qualifying levels, cleared by any gap
  always_ff @(posedge aclk) begin
    pins_q <= pins;
    pins_qq <= pins_q;
    disch_q <= drive.discharge ? disch_q + 1 : 0;
    above_q <= sense.above_upper ? above_q + 1 : 0;
    below_q <= sense.below_lower ? below_q + 1 : 0;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_pw_trip_fast: assert property (steady && pins == 4'h3 &&
    drive.limit == load_detect_pkg::LIM_PW && sense.above_pw_limit |=> !load_present_n)
    else $error("power-wake trip did not assert load present");
  a_pw_disch_len: assert property ($fell(drive.discharge) && steady && pins == 4'h3
    |-> disch_q >= (PW_DISCH_TICKS - 1) * TICK_CYCLES)
    else $error("power-wake discharge too short");
  a_pw_on_high: assert property ($fell(drive.discharge) && steady && pins == 4'h3 &&
    !$past(sense.thermal_hot) |-> drive.switch_on && drive.limit == load_detect_pkg::LIM_HI)
    else $error("switch not back on at high limit");
  a_qual_time: assert property ($fell(load_present_n) && steady && lim_mode &&
    !$past(sense.bc12_detect) |-> above_q >= (QUAL_TICKS - 1) * TICK_CYCLES)
    else $error("load present asserted before qualification");
  a_primary_det: assert property (steady && pins == 4'hf && sense.bc12_detect
    |=> !load_present_n)
    else $error("primary detection did not assert load present");
  a_rel_time: assert property ($rose(load_present_n) && steady && lim_mode
    |-> below_q >= (REL_TICKS - 1) * TICK_CYCLES)
    else $error("load present released too early");
  a_standard_downstream_mode_two_no_disch: assert property ($past(pins) == 4'he && pins == 4'hf &&
    !drive.discharge |=> !drive.discharge [*3])
    else $error("discharge on move to charging-downstream");
  a_limit_stays_hi: assert property (steady && lim_mode && !$past(sense.thermal_hot)
    |-> drive.limit == load_detect_pkg::LIM_HI)
    else $error("port limit not high in charging mode");
  a_hot_off: assert property ($past(sense.thermal_hot) |-> !drive.switch_on)
    else $error("switch on while hot");
  a_hot_retry: assert property (steady && pins == 4'hf && $fell(sense.thermal_hot)
    |=> drive.switch_on)
    else $error("switch did not restart after cooling");
endmodule

/* File: sim/pm_host_model.sv */
// power-management controller model: drives the mode pins, watches load present
// assumes a single peer port whose demand the bench gives as peer_busy
`timescale 1ns/1ps
module pm_host_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // requests from the bench
  input wire logic [3:0] want,
  input wire logic peer_busy,
  // indication from the port
  input wire logic load_present_n,
  // mode pins
  output logic mode_pin_one,
  output logic mode_pin_two,
  output logic mode_pin_three,
  output logic limit_select_pin
);
  logic [3:0] pins_q;
  assign {mode_pin_one, mode_pin_two, mode_pin_three, limit_select_pin} = pins_q;
  // a busy peer demotes this port only while it has no load of its own
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_q <= 4'h0;
    end else if (peer_busy && want == 4'hf && load_present_n) begin
      pins_q <= 4'he;
    end else begin
      pins_q <= want;
    end
  end
endmodule

/* File: sim/tb.sv */
// self-checking bench for the load-detect block: pins, timing, registers, interrupt
// assumes the core files are compiled first and the core folder is on the include path
`timescale 1ns/1ps
`include "load_detect_defines.svh"
module tb;
  // short timer figures so the intervals finish in a few dozen cycles
  localparam int T = 4;
  localparam int PWD = 5;
  localparam int QT = 4;
  localparam int RT = 6;
  localparam int PWR = 8;
  logic aclk, aresetn, peer_busy, load_present_n, irq;
  logic mode_pin_one, mode_pin_two, mode_pin_three, limit_select_pin;
  logic [3:0] want, s_awaddr, s_araddr, s_wstrb;
  load_detect_pkg::sense_t sense;
  load_detect_pkg::port_drive_t drive;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [31:0] s_wdata, s_rdata;
  logic [1:0] s_bresp, s_rresp;
  int err_total, checks_done, cycles, n;

  usb_port_load_detect_ctrl #(.TICK_CYCLES(T), .PW_DISCH_TICKS(PWD), .QUAL_TICKS(QT),
    .REL_TICKS(RT), .PW_REL_TICKS(PWR), .TW(16)) i_usb_port_load_detect_ctrl (.aclk, .aresetn,
    .mode_pin_one, .mode_pin_two, .mode_pin_three, .limit_select_pin, .sense,
    .load_present_n, .drive, .irq, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
  pm_host_model i_pm_host_model (.aclk, .aresetn, .want, .peer_busy, .load_present_n,
    .mode_pin_one, .mode_pin_two, .mode_pin_three, .limit_select_pin);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rng(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("unexpected delay at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // counts settled samples until the chosen output reaches lvl
  task automatic wait_for(input int sel, input logic lvl, output int k);
    logic v;
    k = 0;
    do begin
      @(negedge aclk);
      k++;
      v = (sel == 0) ? load_present_n : drive.discharge;
    end while (v !== lvl && k < 5000);
    @(posedge aclk);
  endtask
  // ready is judged between edges, where it stands settled for the next edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st,
                        input logic [1:0] er);
    logic aw, w, ta, tw;
    logic [1:0] r;
    // start on a rising edge so a back-to-back call never reassigns bready in one step
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= st;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (aw || w) begin
      @(negedge aclk);
      ta = aw && s_awready;
      tw = w && s_wready;
      @(posedge aclk);
      if (ta) begin
        aw = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (tw) begin
        w = 1'b0;
        s_wvalid <= 1'b0;
      end
    end
    do begin
      @(negedge aclk);
      r = s_bresp;
    end while (s_bvalid !== 1'b1);
    @(posedge aclk);
    s_bready <= 1'b0;
    cmp_val(32'(r), 32'(er));
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(negedge aclk); while (s_arready !== 1'b1);
    @(posedge aclk);
    s_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      d = s_rdata;
      r = s_rresp;
    end while (s_rvalid !== 1'b1);
    @(posedge aclk);
    s_rready <= 1'b0;
    cmp_val(d, ed);
    cmp_val(32'(r), 32'(er));
  endtask

  task automatic t_regs;
    axi_rd(`LD_REG_CTRL, `LD_CTRL_RESET, `LD_RESP_OKAY);
    axi_wr(`LD_REG_STATE, 32'h0000_0000, 4'hf, `LD_RESP_SLVERR);
    axi_rd(4'h2, 32'h0000_0000, `LD_RESP_SLVERR);
    axi_wr(`LD_REG_IRQ_MASK, 32'h0000_000f, 4'hf, `LD_RESP_OKAY);
    axi_wr(`LD_REG_IRQ_MASK, 32'h0000_0000, 4'h0, `LD_RESP_OKAY);
    axi_rd(`LD_REG_IRQ_MASK, 32'h0000_000f, `LD_RESP_OKAY);
    cmp_val(32'(irq), 32'h0);
  endtask
  task automatic t_pw;
    want <= 4'h3;
    cyc(4);
    cmp_val(32'(drive.limit), 32'(load_detect_pkg::LIM_PW));
    cmp_val(32'(drive.data_connect), 32'h0);
    sense.above_pw_limit <= 1'b1;
    wait_for(0, 1'b0, n);
    cmp_rng(n, 1, 3);
    sense.above_pw_limit <= 1'b0;
    wait_for(1, 1'b0, n);
    cmp_rng(n, (PWD - 1) * T - 2, PWD * T + 4);
    cmp_val(32'(drive.switch_on), 32'h1);
    cmp_val(32'(drive.limit), 32'(load_detect_pkg::LIM_HI));
    cmp_val(32'(irq), 32'h1);
    axi_rd(`LD_REG_IRQ_STATUS, 32'h0000_0005, `LD_RESP_OKAY);
    cyc(1);
    cmp_val(32'(irq), 32'h0);
    sense.below_pw_low <= 1'b1;
    wait_for(0, 1'b1, n);
    cmp_rng(n, (PWR - 1) * T, PWR * T + 4);
    cyc(2);
    cmp_val(32'(drive.limit), 32'(load_detect_pkg::LIM_PW));
    axi_rd(`LD_REG_IRQ_STATUS, 32'h0000_0002, `LD_RESP_OKAY);
  endtask
  task automatic t_cdp;
    sense.below_pw_low <= 1'b0;
    want <= 4'hf;
    cyc(4);
    cmp_val(32'(drive.limit), 32'(load_detect_pkg::LIM_HI));
    // a run one tick short must not qualify
    sense.above_upper <= 1'b1;
    cyc((QT - 1) * T - 2);
    sense.above_upper <= 1'b0;
    cyc(2 * T);
    cmp_val(32'(load_present_n), 32'h1);
    sense.above_upper <= 1'b1;
    wait_for(0, 1'b0, n);
    cmp_rng(n, (QT - 1) * T, QT * T + 4);
    sense.above_upper <= 1'b0;
    sense.below_lower <= 1'b1;
    wait_for(0, 1'b1, n);
    cmp_rng(n, (RT - 1) * T, RT * T + 4);
    sense.below_lower <= 1'b0;
    sense.bc12_detect <= 1'b1;
    wait_for(0, 1'b0, n);
    cmp_rng(n, 1, 3);
    sense.bc12_detect <= 1'b0;
    sense.below_lower <= 1'b1;
    wait_for(0, 1'b1, n);
    axi_rd(`LD_REG_IRQ_STATUS, 32'h0000_0003, `LD_RESP_OKAY);
  endtask
  task automatic t_ppm;
    peer_busy <= 1'b1;
    cyc(4);
    cmp_val(32'(drive.limit), 32'(load_detect_pkg::LIM_LO));
    peer_busy <= 1'b0;
    repeat (8) begin
      @(negedge aclk);
      cmp_val(32'(drive.discharge), 32'h0);
    end
    cmp_val(32'(drive.limit), 32'(load_detect_pkg::LIM_HI));
    cmp_val(32'(drive.data_connect), 32'h1);
  endtask
  // two thermal-shutdown cycles, the second with the interrupt masked
  task automatic t_hot;
    for (int i = 0; i < 2; i++) begin
      axi_wr(`LD_REG_IRQ_MASK, (i == 0) ? 32'h0000_000f : 32'h0, 4'hf, `LD_RESP_OKAY);
      sense.thermal_hot <= 1'b1;
      cyc(3);
      cmp_val(32'(drive.switch_on), 32'h0);
      cmp_val(32'(irq), (i == 0) ? 32'h1 : 32'h0);
      sense.thermal_hot <= 1'b0;
      cyc(3);
      cmp_val(32'(drive.switch_on), 32'h1);
    end
    axi_rd(`LD_REG_IRQ_STATUS, 32'h0000_0008, `LD_RESP_OKAY);
    // idle charging-downstream state, then enable cleared: switch off and output discharged
    axi_rd(`LD_REG_STATE, 32'h0000_1010, `LD_RESP_OKAY);
    axi_wr(`LD_REG_CTRL, 32'h0000_0000, 4'h1, `LD_RESP_OKAY);
    cyc(2);
    cmp_val(32'({drive.switch_on, drive.discharge}), 32'h1);
    axi_wr(`LD_REG_CTRL, 32'h0000_0001, 4'h1, `LD_RESP_OKAY);
    cyc(2);
    cmp_val(32'({drive.switch_on, drive.discharge}), 32'h2);
  endtask

  initial begin
    err_total = 0;
    checks_done = 0;
    aresetn = 1'b0;
    want = 4'h0;
    peer_busy = 1'b0;
    sense = '0;
    {s_awaddr, s_araddr, s_wstrb, s_wdata} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_pw();
    t_cdp();
    t_ppm();
    t_hot();
    end_sim();
  end
endmodule

bind usb_port_load_detect_ctrl load_detect_chk #(.TICK_CYCLES(TICK_CYCLES),
  .PW_DISCH_TICKS(PW_DISCH_TICKS), .QUAL_TICKS(QUAL_TICKS), .REL_TICKS(REL_TICKS))
  i_load_detect_chk (.aclk, .aresetn, .mode_pin_one, .mode_pin_two, .mode_pin_three,
  .limit_select_pin, .sense, .load_present_n, .drive);
